// ---- verilog/ppp_port.v ----
// Parallel programming port: entry detection, loading, page buffer, memory operations and readback.
`timescale 1ns/1ps
`include "ppp_regs.vh"
module ppp_port (
   input wire CLOCK_IN,
   input wire SYS_RST_IN,
   input wire PROG_VOLTAGE_IN,
   input wire STROBE_CLOCK_IN,
   input wire LOAD_ACTION_B1_IN,
   input wire LOAD_ACTION_B0_IN,
   input wire BYTE_SEL_HI_IN,
   input wire BYTE_SEL_LO_IN,
   input wire BUFFER_LATCH_IN,
   input wire COMMIT_STROBE_N_IN,
   input wire OUT_DRIVE_N_IN,
   input wire [7:0] DATA_IN,
   output reg [7:0] DATA_OUT,
   output wire DATA_OE_N_OUT,
   output wire PROG_DONE_FLAG_OUT,
   output wire PROG_MODE_OUT
);
   localparam ST_IDLE = 2'h0;
   localparam ST_ERASE = 2'h1;
   localparam ST_PAGE = 2'h2;
   localparam ST_EE_PAGE = 2'h3;
   localparam integer ENTRY_HOLD_CYC = `PPP_ENTRY_HOLD_CYC;
   localparam [6:0] ENTRY_HOLD = ENTRY_HOLD_CYC[6:0];
   reg [7:0] prog_mem_lo [0:`PPP_PAGE_WORDS-1];
   reg [7:0] prog_mem_hi [0:`PPP_PAGE_WORDS-1];
   reg [7:0] ee_mem [0:`PPP_EE_PAGE_BYTES-1];
   reg [7:0] cmd_reg;
   reg [23:0] addr_reg;
   reg [7:0] data_lo_reg;
   reg [7:0] data_hi_reg;
   reg [7:0] fuse_lo_reg;
   reg [7:0] fuse_hi_reg;
   reg [7:0] fuse_ext_reg;
   reg [7:0] lock_reg;
   reg [1:0] state_reg;
   reg [6:0] idx_reg;
   reg [2:0] toggles_reg;
   reg [6:0] hold_reg;
   reg entering_reg;
   reg mode_reg;
   reg pv_last_reg;
   reg [3:0] pins_last_reg;
   reg [7:0] rd_byte;
   wire strobe_rise;
   wire latch_rise;
   wire commit_fall;
   wire [1:0] action;
   wire [1:0] bsel;
   wire [3:0] entry_pins;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire fifo_pop;
   wire [23:0] fifo_out;
   wire [23:0] fifo_in;
   wire fifo_push;
   wire busy;
   integer k;
   assign action = {LOAD_ACTION_B1_IN, LOAD_ACTION_B0_IN};
   assign bsel = {BYTE_SEL_HI_IN, BYTE_SEL_LO_IN};
   assign entry_pins = {BUFFER_LATCH_IN, LOAD_ACTION_B1_IN, LOAD_ACTION_B0_IN, BYTE_SEL_LO_IN};
   ppp_edge strobe_edge (
      .clk_in(CLOCK_IN),
      .rst_in(SYS_RST_IN),
      .level_in(STROBE_CLOCK_IN),
      .rise_out(strobe_rise),
      .fall_out(),
      .level_out()
   );
   ppp_edge latch_edge (
      .clk_in(CLOCK_IN),
      .rst_in(SYS_RST_IN),
      .level_in(BUFFER_LATCH_IN),
      .rise_out(latch_rise),
      .fall_out(),
      .level_out()
   );
   ppp_edge commit_edge (
      .clk_in(CLOCK_IN),
      .rst_in(SYS_RST_IN),
      .level_in(COMMIT_STROBE_N_IN),
      .rise_out(),
      .fall_out(commit_fall),
      .level_out()
   );
   // True when the command is one of the two page-write commands.
   function is_write_cmd;
      input [7:0] c;
      begin
         is_write_cmd = (c == `PPP_CMD_WR_PROG) || (c == `PPP_CMD_WR_EE);
      end
   endfunction
   assign busy = (state_reg != ST_IDLE) || fifo_out_valid;
   assign PROG_DONE_FLAG_OUT = !busy;
   assign PROG_MODE_OUT = mode_reg;
   // Latched words carry {ee flag, word index, high byte, low byte}; the page buffer drains into storage.
   assign fifo_in = {cmd_reg == `PPP_CMD_WR_EE, addr_reg[`PPP_WORD_BITS-1:0], data_hi_reg, data_lo_reg};
   assign fifo_push = mode_reg && latch_rise && is_write_cmd(cmd_reg);
   // Drain runs in every idle cycle without a commit edge, so latched words leave the buffer one per clock.
   assign fifo_pop = fifo_out_valid && (state_reg == ST_IDLE) && !commit_fall;
   ppp_fifo #(
      .WIDTH(24),
      .DEPTH(`PPP_FIFO_DEPTH),
      .AW(`PPP_FIFO_AW)
   ) page_fifo (
      .clk_in(CLOCK_IN),
      .rst_in(SYS_RST_IN),
      .in_valid_in(fifo_push),
      .in_ready_out(fifo_in_ready),
      .in_data_in(fifo_in),
      .out_valid_out(fifo_out_valid),
      .out_ready_in(fifo_pop),
      .out_data_out(fifo_out)
   );
   // Entry: count strobe toggles with the programming voltage low, then require quiet entry pins after the voltage rise.
   always @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         toggles_reg <= 3'h0;
         hold_reg <= 7'h00;
         entering_reg <= 1'b0;
         mode_reg <= 1'b0;
         pv_last_reg <= 1'b0;
         pins_last_reg <= 4'h0;
      end else begin
         pv_last_reg <= PROG_VOLTAGE_IN;
         pins_last_reg <= entry_pins;
         if (!PROG_VOLTAGE_IN) begin
            mode_reg <= 1'b0;
            entering_reg <= 1'b0;
            if (strobe_rise && toggles_reg != 3'h7) begin
               toggles_reg <= toggles_reg + 3'h1;
            end
         end else if (!pv_last_reg) begin
            entering_reg <= (toggles_reg >= `PPP_PRE_TOGGLES) && (entry_pins == 4'h0);
            hold_reg <= 7'h00;
            toggles_reg <= 3'h0;
         end else if (entering_reg) begin
            if (entry_pins != pins_last_reg) begin
               entering_reg <= 1'b0;
            end else if (hold_reg + 7'h01 >= ENTRY_HOLD) begin
               entering_reg <= 1'b0;
               mode_reg <= 1'b1;
            end else begin
               hold_reg <= hold_reg + 7'h01;
            end
         end
      end
   end
   // Loading, operations and storage.
   always @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         cmd_reg <= `PPP_CMD_NOP;
         addr_reg <= 24'h000000;
         data_lo_reg <= 8'h00;
         data_hi_reg <= 8'h00;
         fuse_lo_reg <= `PPP_FUSE_LO_RESET;
         fuse_hi_reg <= `PPP_FUSE_HI_RESET;
         fuse_ext_reg <= `PPP_FUSE_EXT_RESET;
         lock_reg <= `PPP_LOCK_RESET;
         state_reg <= ST_IDLE;
         idx_reg <= 7'h00;
         for (k = 0; k < `PPP_PAGE_WORDS; k = k + 1) begin
            prog_mem_lo[k] <= `PPP_ERASED_BYTE;
            prog_mem_hi[k] <= `PPP_ERASED_BYTE;
         end
         for (k = 0; k < `PPP_EE_PAGE_BYTES; k = k + 1) begin
            ee_mem[k] <= `PPP_ERASED_BYTE;
         end
      end else begin
         // Command and address stay until reloaded, so one command serves many locations.
         if (mode_reg && strobe_rise && !busy) begin
            case (action)
               `PPP_ACT_ADDR: begin
                  if (bsel == `PPP_BS_LO) begin
                     addr_reg[7:0] <= DATA_IN;
                  end else if (bsel == `PPP_BS_HI) begin
                     addr_reg[15:8] <= DATA_IN;
                  end else if (bsel == `PPP_BS_EXT) begin
                     addr_reg[23:16] <= DATA_IN;
                  end
               end
               `PPP_ACT_DATA: begin
                  if (bsel == `PPP_BS_LO) begin
                     data_lo_reg <= DATA_IN;
                  end else if (bsel == `PPP_BS_HI) begin
                     data_hi_reg <= DATA_IN;
                  end
               end
               `PPP_ACT_CMD: begin
                  cmd_reg <= DATA_IN;
               end
               default: begin
               end
            endcase
         end
         if (fifo_pop) begin
            if (fifo_out[23]) begin
               ee_mem[fifo_out[18:16]] <= fifo_out[7:0];
            end
         end
         case (state_reg)
            ST_IDLE: begin
               if (mode_reg && commit_fall && !fifo_out_valid) begin
                  if (cmd_reg == `PPP_CMD_ERASE) begin
                     state_reg <= ST_ERASE;
                     idx_reg <= 7'h00;
                  end else if (cmd_reg == `PPP_CMD_WR_FUSE) begin
                     if (bsel == `PPP_BS_LO) begin
                        fuse_lo_reg <= data_lo_reg;
                     end else if (bsel == `PPP_BS_HI) begin
                        fuse_hi_reg <= data_lo_reg;
                     end else if (bsel == `PPP_BS_EXT) begin
                        fuse_ext_reg <= data_lo_reg;
                     end
                  end else if (cmd_reg == `PPP_CMD_WR_LOCK) begin
                     lock_reg <= lock_reg & data_lo_reg;
                  end else if (cmd_reg == `PPP_CMD_WR_PROG && bsel == `PPP_BS_LO) begin
                     state_reg <= ST_PAGE;
                  end else if (cmd_reg == `PPP_CMD_WR_EE && bsel == `PPP_BS_LO) begin
                     state_reg <= ST_EE_PAGE;
                  end
               end
            end
            ST_ERASE: begin
               prog_mem_lo[idx_reg] <= `PPP_ERASED_BYTE;
               prog_mem_hi[idx_reg] <= `PPP_ERASED_BYTE;
               if (fuse_hi_reg[`PPP_FUSE_HI_KEEP_EE_BIT] && idx_reg < `PPP_EE_PAGE_BYTES) begin
                  ee_mem[idx_reg[2:0]] <= `PPP_ERASED_BYTE;
               end
               idx_reg <= idx_reg + 7'h01;
               if (idx_reg == 7'h7F) begin
                  lock_reg <= `PPP_LOCK_RESET;
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
         // Program words land in the page at their word index; the upper bit of the low address byte is ignored.
         if (fifo_pop && !fifo_out[23]) begin
            prog_mem_lo[fifo_out[22:16] & 7'h7F] <= fifo_out[7:0];
            prog_mem_hi[fifo_out[22:16] & 7'h7F] <= fifo_out[15:8];
         end
      end
   end
   // Readback multiplexer; signature read returns 8'h5A with BYTE_SEL_LO_IN high, else the two low address bits.
   always @* begin
      rd_byte = 8'h00;
      if (cmd_reg == `PPP_CMD_RD_PROG) begin
         rd_byte = BYTE_SEL_LO_IN ? prog_mem_hi[addr_reg[6:0]] : prog_mem_lo[addr_reg[6:0]];
      end else if (cmd_reg == `PPP_CMD_RD_EE) begin
         rd_byte = ee_mem[addr_reg[2:0]];
      end else if (cmd_reg == `PPP_CMD_RD_FUSE) begin
         if (bsel == `PPP_BS_LO) begin
            rd_byte = fuse_lo_reg;
         end else if (bsel == `PPP_BS_HI) begin
            rd_byte = lock_reg;
         end else if (bsel == `PPP_BS_EXT) begin
            rd_byte = fuse_ext_reg;
         end else begin
            rd_byte = fuse_hi_reg;
         end
      end else if (cmd_reg == `PPP_CMD_RD_SIG) begin
         rd_byte = BYTE_SEL_LO_IN ? 8'h5A : {6'h00, addr_reg[1:0]};
      end
   end
   always @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         DATA_OUT <= 8'h00;
      end else begin
         DATA_OUT <= rd_byte;
      end
   end
   // Bus is only driven inside programming mode while output drive is requested.
   assign DATA_OE_N_OUT = !(mode_reg && !OUT_DRIVE_N_IN);
   // Page buffer stays writable because pushes beyond depth are dropped rather than stalling the pins.
   wire unused_ready;
   assign unused_ready = fifo_in_ready;
endmodule // ppp_port

// ---- verilog/ppp_regs.vh ----
// Constants for the parallel programming port: codes, field positions, sizes and timing counts.
`ifndef PPP_REGS_VH
`define PPP_REGS_VH
`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
`define PPP_ACT_IDLE 2'h3
`define PPP_CMD_NOP 8'h00
`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WR_FUSE 8'h40
`define PPP_CMD_WR_LOCK 8'h20
`define PPP_CMD_WR_PROG 8'h10
`define PPP_CMD_WR_EE 8'h11
`define PPP_CMD_RD_SIG 8'h08
`define PPP_CMD_RD_FUSE 8'h04
`define PPP_CMD_RD_PROG 8'h02
`define PPP_CMD_RD_EE 8'h03
`define PPP_BS_LO 2'h0
`define PPP_BS_HI 2'h1
`define PPP_BS_EXT 2'h2
`define PPP_BS_RSV 2'h3
`define PPP_WORD_BITS 7
`define PPP_PAGE_WORDS 128
`define PPP_PROG_ADDR_BITS 16
`define PPP_EE_BYTE_BITS 3
`define PPP_EE_PAGE_BYTES 8
`define PPP_EE_ADDR_BITS 12
`define PPP_ERASED_BYTE 8'hFF
`define PPP_LOCK_RESET 8'hFF
`define PPP_FUSE_LO_RESET 8'h5E
`define PPP_FUSE_HI_RESET 8'h99
`define PPP_FUSE_EXT_RESET 8'hF3
`define PPP_FUSE_HI_KEEP_EE_BIT 3
`define PPP_CLK_NS 5
`define PPP_ENTRY_HOLD_NS 100
`define PPP_ENTRY_HOLD_CYC ((`PPP_ENTRY_HOLD_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS)
`define PPP_PRE_TOGGLES 6
`define PPP_FIFO_DEPTH 16
`define PPP_FIFO_AW 4
`endif

// ---- verilog/ppp_fifo.v ----
// Parameterised valid/ready FIFO of flip-flops that buffers latched page words.
`timescale 1ns/1ps
module ppp_fifo #(
   parameter WIDTH = 23,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk_in,
   input wire rst_in,
   input wire in_valid_in,
   output wire in_ready_out,
   input wire [WIDTH-1:0] in_data_in,
   output wire out_valid_out,
   input wire out_ready_in,
   output wire [WIDTH-1:0] out_data_out
);
   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   wire push;
   wire pop;
   integer i;
   assign in_ready_out = (count_reg != DEPTH[AW:0]);
   assign out_valid_out = (count_reg != {(AW+1){1'b0}});
   assign out_data_out = mem_reg[rd_ptr_reg];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_reg[i] <= {WIDTH{1'b0}};
         end
      end else begin
         if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_in;
            wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
         end
         if (push && !pop) begin
            count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
         end else if (pop && !push) begin
            count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule // ppp_fifo

// ---- verilog/ppp_edge.v ----
// Edge detector that turns a synchronous pin level into single-cycle rise and fall events.
`timescale 1ns/1ps
module ppp_edge (
   input wire clk_in,
   input wire rst_in,
   input wire level_in,
   output wire rise_out,
   output wire fall_out,
   output wire level_out
);
   reg last_reg;
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         last_reg <= 1'b0;
      end else begin
         last_reg <= level_in;
      end
   end
   assign rise_out = level_in && !last_reg;
   assign fall_out = !level_in && last_reg;
   assign level_out = last_reg;
endmodule // ppp_edge

// ---- bench/ppp_port_sva.sv ----
// Assertion checker for the parallel programming port, bound to its top module.
`timescale 1ns/1ps
`include "ppp_regs.vh"
module ppp_port_sva (
   input wire CLOCK_IN,
   input wire SYS_RST_IN,
   input wire PROG_VOLTAGE_IN,
   input wire STROBE_CLOCK_IN,
   input wire LOAD_ACTION_B1_IN,
   input wire LOAD_ACTION_B0_IN,
   input wire BYTE_SEL_HI_IN,
   input wire BYTE_SEL_LO_IN,
   input wire BUFFER_LATCH_IN,
   input wire COMMIT_STROBE_N_IN,
   input wire OUT_DRIVE_N_IN,
   input wire [7:0] DATA_IN,
   input wire [7:0] DATA_OUT,
   input wire DATA_OE_N_OUT,
   input wire PROG_DONE_FLAG_OUT,
   input wire PROG_MODE_OUT
);
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (SYS_RST_IN);
   wire [3:0] pins = {BUFFER_LATCH_IN, LOAD_ACTION_B1_IN, LOAD_ACTION_B0_IN, BYTE_SEL_LO_IN};
   wire [6:0] sel = {BYTE_SEL_HI_IN, BYTE_SEL_LO_IN, STROBE_CLOCK_IN, BUFFER_LATCH_IN, COMMIT_STROBE_N_IN,
      OUT_DRIVE_N_IN, PROG_MODE_OUT};
   reg [3:0] pins_reg;
   reg strobe_reg;
   reg [7:0] cmd_reg;
   reg [4:0] quiet_reg;
   reg [2:0] rises_reg;
   reg [7:0] low_reg;
   reg volt_reg;
   wire rise = STROBE_CLOCK_IN & ~strobe_reg;
   always @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         pins_reg <= 4'h0;
         strobe_reg <= 1'b0;
         cmd_reg <= 8'h00;
         quiet_reg <= 5'h00;
         rises_reg <= 3'h0;
         low_reg <= 8'h00;
         volt_reg <= 1'b0;
      end else begin
         pins_reg <= pins;
         volt_reg <= PROG_VOLTAGE_IN;
         strobe_reg <= STROBE_CLOCK_IN;
         if (rise && pins[2:1] == `PPP_ACT_CMD && PROG_DONE_FLAG_OUT && PROG_MODE_OUT)
            cmd_reg <= DATA_IN;
         // Any pin change restarts the quiet count, since the entry hold must be unbroken.
         if (!PROG_VOLTAGE_IN || pins != pins_reg)
            quiet_reg <= 5'h00;
         else if (quiet_reg != 5'h1F)
            quiet_reg <= quiet_reg + 5'h01;
         // A strobe rise in the cycle of the voltage drop still counts, or a prompt programmer looks one short.
         if (!PROG_VOLTAGE_IN && volt_reg)
            rises_reg <= {2'h0, rise};
         else if (!PROG_VOLTAGE_IN && rise && rises_reg != 3'h7)
            rises_reg <= rises_reg + 3'h1;
         if (PROG_DONE_FLAG_OUT)
            low_reg <= 8'h00;
         else if (low_reg != 8'hFF)
            low_reg <= low_reg + 8'h01;
      end
   end
   AST_OE_OFF: assert property (OUT_DRIVE_N_IN |-> DATA_OE_N_OUT)
      else $error("device drives bus while read enable is high");
   AST_OE_ON: assert property (PROG_MODE_OUT && !OUT_DRIVE_N_IN |-> !DATA_OE_N_OUT)
      else $error("device does not drive bus on read");
   AST_ERASE_START: assert property ($fell(COMMIT_STROBE_N_IN) && PROG_MODE_OUT && PROG_DONE_FLAG_OUT &&
      cmd_reg == `PPP_CMD_ERASE |-> ##[1:4] !PROG_DONE_FLAG_OUT)
      else $error("erase commit did not show busy");
   AST_ERASE_LEN: assert property ($rose(PROG_DONE_FLAG_OUT) && cmd_reg == `PPP_CMD_ERASE |-> low_reg == 8'h80)
      else $error("erase busy length wrong");
   AST_ENTRY_QUIET: assert property ($rose(PROG_MODE_OUT) |-> quiet_reg >= 5'd19)
      else $error("mode entered without quiet hold");
   AST_ENTRY_TOGGLES: assert property ($rose(PROG_MODE_OUT) |-> rises_reg >= 3'd6)
      else $error("mode entered with too few strobe toggles");
   AST_ENTRY_PINS: assert property ($rose(PROG_MODE_OUT) |-> pins == 4'h0)
      else $error("mode entered with nonzero entry pins");
   AST_READ_STEADY: assert property ((PROG_DONE_FLAG_OUT && $stable(sel)) [*4] |-> $stable(DATA_OUT))
      else $error("read byte changed without an input event");
   cover property ($rose(PROG_MODE_OUT));
   cover property ($rose(PROG_DONE_FLAG_OUT) && cmd_reg == `PPP_CMD_ERASE);
   cover property (!DATA_OE_N_OUT && BYTE_SEL_LO_IN);
endmodule // ppp_port_sva
bind ppp_port ppp_port_sva i_sva (.CLOCK_IN, .SYS_RST_IN, .PROG_VOLTAGE_IN, .STROBE_CLOCK_IN, .LOAD_ACTION_B1_IN,
   .LOAD_ACTION_B0_IN, .BYTE_SEL_HI_IN, .BYTE_SEL_LO_IN, .BUFFER_LATCH_IN, .COMMIT_STROBE_N_IN, .OUT_DRIVE_N_IN,
   .DATA_IN, .DATA_OUT, .DATA_OE_N_OUT, .PROG_DONE_FLAG_OUT, .PROG_MODE_OUT);

// ---- bench/ppp_prog_model.sv ----
// Programmer-side model of the shared data bus.
`timescale 1ns/1ps
module ppp_prog_model (
   input wire clk_in,
   input wire [7:0] dev_data_in,
   input wire dev_oe_n_in,
   input wire [7:0] host_data_in,
   input wire host_oe_n_in,
   output wire [7:0] bus_out
);
   reg [7:0] last_reg = 8'h00;
   always @(posedge clk_in) begin
      last_reg <= bus_out;
   end
   // A released bus shows the inverse of its last level, so a stale byte never passes for an answer.
   assign bus_out = !dev_oe_n_in ? dev_data_in : (!host_oe_n_in ? host_data_in : ~last_reg);
endmodule // ppp_prog_model

// ---- bench/tb.sv ----
// Self-checking testbench that plays the programmer through the parallel programming port.
`timescale 1ns/1ps
`include "ppp_regs.vh"
module tb;
   localparam integer P = 50;
   localparam [1:0] AD = `PPP_ACT_ADDR;
   localparam [1:0] DT = `PPP_ACT_DATA;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg volt = 1'b0;
   reg stb = 1'b0;
   reg [1:0] act = 2'h0;
   reg [1:0] bs = 2'h0;
   reg latch = 1'b0;
   reg wr_n = 1'b1;
   reg oe_n = 1'b1;
   reg [7:0] hdat = 8'h00;
   wire [7:0] bus;
   wire [7:0] dout;
   wire oe_dev_n;
   wire done;
   wire mode;
   integer err_count = 0;
   integer num_checks = 0;
   always #2.5 clk = ~clk;
   ppp_port i_dut (.CLOCK_IN(clk), .SYS_RST_IN(rst), .PROG_VOLTAGE_IN(volt), .STROBE_CLOCK_IN(stb),
      .LOAD_ACTION_B1_IN(act[1]), .LOAD_ACTION_B0_IN(act[0]), .BYTE_SEL_HI_IN(bs[1]), .BYTE_SEL_LO_IN(bs[0]),
      .BUFFER_LATCH_IN(latch), .COMMIT_STROBE_N_IN(wr_n), .OUT_DRIVE_N_IN(oe_n), .DATA_IN(bus),
      .DATA_OUT(dout), .DATA_OE_N_OUT(oe_dev_n), .PROG_DONE_FLAG_OUT(done), .PROG_MODE_OUT(mode));
   ppp_prog_model i_prog (.clk_in(clk), .dev_data_in(dout), .dev_oe_n_in(oe_dev_n), .host_data_in(hdat),
      .host_oe_n_in(~oe_n), .bus_out(bus));
   task chk(input [7:0] got, input [7:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d mismatches %0d", num_checks, err_count);
         if (err_count == 0 && num_checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task wait_rdy;
      integer n;
      begin
         n = 0;
         while (done !== 1'b1 && n < 400) begin
            @(negedge clk);
            n = n + 1;
         end
         if (done !== 1'b1) begin
            chk(8'h00, 8'h01);
            finish_test;
         end
      end
   endtask
   task load(input [1:0] a, input [1:0] b, input [7:0] d);
      begin
         wait_rdy;
         act = a;
         bs = b;
         hdat = d;
         repeat (P) @(negedge clk);
         stb = 1'b1;
         repeat (P) @(negedge clk);
         stb = 1'b0;
      end
   endtask
   task cmd(input [7:0] c);
      load(`PPP_ACT_CMD, 2'h0, c);
   endtask
   task commit(input [1:0] b);
      begin
         repeat (4) @(negedge clk);
         wait_rdy;
         bs = b;
         repeat (P) @(negedge clk);
         wr_n = 1'b0;
         repeat (P) @(negedge clk);
         wr_n = 1'b1;
         repeat (4) @(negedge clk);
         wait_rdy;
      end
   endtask
   task pword(input [7:0] a, input [15:0] w);
      begin
         load(AD, 2'h0, a);
         load(DT, 2'h0, w[7:0]);
         load(DT, 2'h1, w[15:8]);
         latch = 1'b1;
         repeat (P) @(negedge clk);
         latch = 1'b0;
         repeat (P) @(negedge clk);
      end
   endtask
   task rd(input [1:0] b, input [7:0] exp);
      begin
         bs = b;
         oe_n = 1'b0;
         repeat (4) @(negedge clk);
         chk(bus, exp);
         oe_n = 1'b1;
         @(negedge clk);
      end
   endtask
   task enter(input glitch);
      begin
         volt = 1'b0;
         act = 2'h0;
         bs = 2'h0;
         repeat (6) begin
            stb = 1'b1;
            repeat (P) @(negedge clk);
            stb = 1'b0;
            repeat (P) @(negedge clk);
         end
         repeat (20) @(negedge clk);
         volt = 1'b1;
         if (glitch) begin
            repeat (10) @(negedge clk);
            bs[0] = 1'b1;
            @(negedge clk);
            bs[0] = 1'b0;
         end
         repeat (100) @(negedge clk);
      end
   endtask
   initial begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      enter(1'b1);
      chk({7'h00, mode}, 8'h00);
      enter(1'b0);
      chk({7'h00, mode}, 8'h01);
      repeat (10000) @(negedge clk);
      $display("test entry done");
      cmd(`PPP_CMD_RD_FUSE);
      rd(2'h0, `PPP_FUSE_LO_RESET);
      rd(2'h1, `PPP_LOCK_RESET);
      rd(2'h2, `PPP_FUSE_EXT_RESET);
      rd(2'h3, `PPP_FUSE_HI_RESET);
      cmd(`PPP_CMD_WR_FUSE);
      load(DT, 2'h0, 8'h91);
      commit(2'h1);
      cmd(`PPP_CMD_WR_LOCK);
      load(DT, 2'h0, 8'hFC);
      commit(2'h0);
      cmd(`PPP_CMD_RD_FUSE);
      rd(2'h3, 8'h91);
      rd(2'h1, 8'hFC);
      rd(2'h0, `PPP_FUSE_LO_RESET);
      $display("test fuses done");
      cmd(`PPP_CMD_WR_EE);
      load(AD, 2'h1, 8'h00);
      load(AD, 2'h2, 8'h00);
      pword(8'h05, 16'h00A5);
      commit(2'h0);
      cmd(`PPP_CMD_RD_EE);
      rd(2'h0, 8'hA5);
      $display("test eeprom done");
      cmd(`PPP_CMD_WR_PROG);
      pword(8'h03, 16'h1234);
      pword(8'h7F, 16'hBEEF);
      commit(2'h0);
      cmd(`PPP_CMD_NOP);
      pword(8'h03, 16'h5555);
      cmd(`PPP_CMD_RD_PROG);
      load(AD, 2'h0, 8'h03);
      load(`PPP_ACT_IDLE, 2'h0, 8'h7F);
      rd(2'h0, 8'h34);
      rd(2'h1, 8'h12);
      load(AD, 2'h0, 8'h7F);
      rd(2'h0, 8'hEF);
      rd(2'h1, 8'hBE);
      cmd(`PPP_CMD_RD_SIG);
      load(AD, 2'h0, 8'h00);
      rd(2'h1, 8'h5A);
      $display("test flash done");
      cmd(`PPP_CMD_ERASE);
      commit(2'h0);
      cmd(`PPP_CMD_RD_PROG);
      load(AD, 2'h0, 8'h03);
      rd(2'h0, `PPP_ERASED_BYTE);
      cmd(`PPP_CMD_RD_EE);
      load(AD, 2'h0, 8'h05);
      rd(2'h0, 8'hA5);
      cmd(`PPP_CMD_RD_FUSE);
      rd(2'h1, `PPP_LOCK_RESET);
      rd(2'h3, 8'h91);
      $display("test erase done");
      finish_test;
   end
endmodule // tb
